/* rtl/hsmfd_params.svh */
`ifndef HSMFD_PARAMS_SVH
`define HSMFD_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define HSMFD_REF_CLK_MHZ     200
`define HSMFD_SYNC_CLK_MHZ    4
`define HSMFD_SYNC_DIV        (`HSMFD_REF_CLK_MHZ / `HSMFD_SYNC_CLK_MHZ)

// ****************************************
// Line counter marks
// ****************************************
`define HSMFD_CNT_ZERO        8'h00
`define HSMFD_CNT_MASK_ON     8'h01
`define HSMFD_CNT_PULSE_END   8'h0A
`define HSMFD_CNT_FIELD_CLR   8'h46

// ****************************************
// Register map
// ****************************************
`define HSMFD_OFS_VSC         12'h000
`define HSMFD_OFS_HCTL        12'h004
`define HSMFD_OFS_SCMP        12'h008
`define HSMFD_OFS_LINE        12'h00C

`define HSMFD_VSC_EN_BIT      0
`define HSMFD_VSC_SELA_BIT    1
`define HSMFD_VSC_SELB_BIT    2
`define HSMFD_VSC_FLAG_BIT    8
`define HSMFD_VSC_VALID_BIT   9
`define HSMFD_VSC_VS_BIT      10
`define HSMFD_VSC_MASK_BIT    11

`define HSMFD_LO_BYTE         7:0
`define HSMFD_HI_BYTE         15:8

`define HSMFD_RST_MASKW       8'h0A
`define HSMFD_RST_COMP        8'hFF
`define HSMFD_RST_HCMP        8'h04
`define HSMFD_RST_VCMP        8'h40
`define HSMFD_ZERO32          32'h0000_0000

`endif

/* rtl/hsmfd_pkg.sv */
package hsmfd_pkg;

	typedef enum logic [1:0] {
		LS_IDLE,
		LS_WAIT,
		LS_RUN
	} hsmfd_line_state_t;

	typedef logic [7:0] hsmfd_byte_t;

endpackage : hsmfd_pkg

/* rtl/hsmfd_sync_counter.sv */
`timescale 1ns/1ps
`include "hsmfd_params.svh"

module hsmfd_sync_counter #(
	parameter int CNT_W = 8
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// Control
	input  wire logic             syncTick,
	input  wire logic             enable,
	input  wire logic             syncIn,
	input  wire logic [CNT_W-1:0] hMatchCmp,
	input  wire logic [CNT_W-1:0] vMatchCmp,
	// Results
	output logic                  hMatch_q,
	output logic                  vertical_sync_out_q
);
	import hsmfd_pkg::*;

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] countUp;
	logic [CNT_W-1:0] countDn;
	logic             atTop;
	logic             atBottom;
	logic             hMatch_d;
	logic             vertical_sync_out_d;

	assign countUp  = CNT_W'(count_q + 1'b1);
	assign countDn  = CNT_W'(count_q - 1'b1);
	assign atTop    = (count_q == vMatchCmp);
	assign atBottom = (count_q == '0);
	// Saturates at the vertical compare and at zero
	assign count_d  = syncIn ? (atTop ? count_q : countUp) :
	                  (atBottom ? count_q : countDn);
	// Only an up-count step lands a horizontal match
	assign hMatch_d = syncIn & ~atTop & (countUp == hMatchCmp);
	assign vertical_sync_out_d  = (count_d == vMatchCmp) ? 1'b1 :
	                  ((count_d == '0) ? 1'b0 : vertical_sync_out_q);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q  <= '0;
			hMatch_q <= 1'b0;
			vertical_sync_out_q  <= 1'b0;
		end else if (!enable) begin
			count_q  <= '0;
			hMatch_q <= 1'b0;
			vertical_sync_out_q  <= 1'b0;
		end else if (syncTick) begin
			count_q  <= count_d;
			hMatch_q <= hMatch_d;
			vertical_sync_out_q  <= vertical_sync_out_d;
		end
	end

endmodule : hsmfd_sync_counter

/* rtl/hsmfd_top.sv */
`timescale 1ns/1ps
`include "hsmfd_params.svh"

module hsmfd_top #(
	parameter int SYNC_DIV = `HSMFD_SYNC_DIV,
	parameter int CNT_W    = 8
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Composite sync
	input  wire logic        compositeSyncIn,
	// Sync outputs
	output logic             rawHsyncOut,
	output logic             compensatedHsyncOut,
	output logic             verticalSyncOut,
	output logic             fieldFlagOut,
	// Timer count sources
	output logic             lineDropTimerATick,
	output logic             lineDropTimerBTick
);
	import hsmfd_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	localparam int DIV_W = (SYNC_DIV > 1) ? $clog2(SYNC_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYNC_DIV - 1);

	logic [DIV_W-1:0]  divCnt_q;
	logic              syncTick_q;

	logic              sepEnable_q;
	logic              selTimerA_q;
	logic              selTimerB_q;
	hsmfd_byte_t       maskWidthCmp_q;
	hsmfd_byte_t       compCmp_q;
	hsmfd_byte_t       hMatchCmp_q;
	hsmfd_byte_t       vMatchCmp_q;

	hsmfd_line_state_t lineState_q;
	hsmfd_line_state_t lineState_d;
	hsmfd_byte_t       lineCnt_q;
	hsmfd_byte_t       lineCnt_d;
	hsmfd_byte_t       lineCntInc;
	logic              hMask_q;
	logic              hMask_d;
	logic              rawHs_q;
	logic              rawHs_d;
	logic              compPulse_q;
	logic              compPulse_d;
	logic              compHs_q;
	logic              compHs_d;
	logic              fieldFf_q;
	logic              fieldFf_d;
	logic              fieldFlag_q;
	logic              vsPrev_q;
	logic [1:0]        vsSeen_q;
	logic              fieldValid;
	logic              timerATick_q;
	logic              timerBTick_q;

	logic              hMatch;
	logic              vertical_sync_out;
	logic              running;
	logic              accept;
	logic              compHit;
	logic              restart;
	logic              compRise;
	logic              rawRise;
	logic              vsRise;

	logic              apbSetup;
	logic              apbWrite;
	logic              hitVsc;
	logic              hitHctl;
	logic              hitScmp;
	logic              hitLine;
	logic              hitAny;
	logic [31:0]       vscRead;
	logic [31:0]       readMux;
	logic [31:0]       prdata_q;
	logic              pready_q;
	logic              pslverr_q;

	// ****************************************
	// Separator clock enable
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_q   <= '0;
			syncTick_q <= 1'b0;
		end else begin
			divCnt_q   <= (divCnt_q == DIV_LAST) ? '0 : DIV_W'(divCnt_q + 1'b1);
			syncTick_q <= (divCnt_q == DIV_LAST);
		end
	end

	// ****************************************
	// Sampling up/down counter
	// ****************************************
	hsmfd_sync_counter #(
		.CNT_W     (CNT_W)
	) u_sync_counter (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.syncTick  (syncTick_q),
		.enable    (sepEnable_q),
		.syncIn    (compositeSyncIn),
		.hMatchCmp (hMatchCmp_q),
		.vMatchCmp (vMatchCmp_q),
		.hMatch_q  (hMatch),
		.vertical_sync_out_q   (vertical_sync_out)
	);

	// ****************************************
	// Line counter decode
	// ****************************************
	assign running    = (lineState_q == LS_RUN);
	assign accept     = hMatch & ~hMask_q;
	assign compHit    = running & ~accept & (lineCnt_q == compCmp_q);
	assign restart    = accept | compHit;
	assign lineCntInc = 8'(lineCnt_q + 1'b1);
	// Without a match the counter runs on in LS_RUN until compCmp_q restarts it
	assign lineCnt_d  = restart ? `HSMFD_CNT_ZERO :
	                    (running ? lineCntInc : lineCnt_q);

	// Mask rises one count after any restart and falls at the width compare
	assign hMask_d = (lineCnt_d == `HSMFD_CNT_MASK_ON) ? 1'b1 :
	                 ((lineCnt_d == maskWidthCmp_q) ? 1'b0 : hMask_q);

	// Raw sync has a fixed width; self-generated lines never set it
	assign rawHs_d = accept ? 1'b1 :
	                 ((lineCnt_d == `HSMFD_CNT_PULSE_END) ? 1'b0 : rawHs_q);
	assign compPulse_d = compHit ? 1'b1 :
	                     ((lineCnt_d == `HSMFD_CNT_PULSE_END) ? 1'b0 : compPulse_q);
	assign compHs_d = rawHs_d | compPulse_d;
	assign compRise = compHs_d & ~compHs_q;
	assign rawRise  = rawHs_d & ~rawHs_q;

	// Set has priority; the clear mark lies far past the pulse anyway
	assign fieldFf_d = compRise ? 1'b1 :
	                   ((lineCnt_d == `HSMFD_CNT_FIELD_CLR) ? 1'b0 : fieldFf_q);

	assign vsRise     = vertical_sync_out & ~vsPrev_q;
	assign fieldValid = vsSeen_q[1];

	always_comb begin
		lineState_d = lineState_q;
		case (lineState_q)
			LS_IDLE: begin
				if (sepEnable_q) begin
					lineState_d = LS_WAIT;
				end
			end
			LS_WAIT: begin
				if (accept) begin
					lineState_d = LS_RUN;
				end
			end
			LS_RUN: begin
				lineState_d = LS_RUN;
			end
			default: begin
				lineState_d = LS_IDLE;
			end
		endcase
	end

	// ****************************************
	// Line counter and sync flops
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lineState_q <= LS_IDLE;
			lineCnt_q   <= `HSMFD_CNT_ZERO;
			hMask_q     <= 1'b0;
			rawHs_q     <= 1'b0;
			compPulse_q <= 1'b0;
			compHs_q    <= 1'b0;
			fieldFf_q   <= 1'b0;
		end else if (!sepEnable_q) begin
			lineState_q <= LS_IDLE;
			lineCnt_q   <= `HSMFD_CNT_ZERO;
			hMask_q     <= 1'b0;
			rawHs_q     <= 1'b0;
			compPulse_q <= 1'b0;
			compHs_q    <= 1'b0;
			fieldFf_q   <= 1'b0;
		end else if (syncTick_q) begin
			lineState_q <= lineState_d;
			lineCnt_q   <= lineCnt_d;
			hMask_q     <= hMask_d;
			rawHs_q     <= rawHs_d;
			compPulse_q <= compPulse_d;
			compHs_q    <= compHs_d;
			fieldFf_q   <= fieldFf_d;
		end
	end

	// ****************************************
	// Field discrimination
	// ****************************************
	// Flag is kept across a disable so software can still read the last field
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fieldFlag_q <= 1'b0;
			vsPrev_q    <= 1'b0;
			vsSeen_q    <= 2'b00;
		end else if (!sepEnable_q) begin
			vsPrev_q <= 1'b0;
			vsSeen_q <= 2'b00;
		end else if (syncTick_q) begin
			vsPrev_q <= vertical_sync_out;
			if (vsRise) begin
				fieldFlag_q <= fieldFf_q;
				vsSeen_q    <= fieldValid ? vsSeen_q : 2'(vsSeen_q + 1'b1);
			end
		end
	end

	// ****************************************
	// Timer count sources
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			timerATick_q <= 1'b0;
			timerBTick_q <= 1'b0;
		end else begin
			timerATick_q <= syncTick_q & sepEnable_q & rawRise & selTimerA_q;
			timerBTick_q <= syncTick_q & sepEnable_q & rawRise & selTimerB_q;
		end
	end

	// ****************************************
	// APB decode
	// ****************************************
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign hitVsc   = (paddr == `HSMFD_OFS_VSC);
	assign hitHctl  = (paddr == `HSMFD_OFS_HCTL);
	assign hitScmp  = (paddr == `HSMFD_OFS_SCMP);
	assign hitLine  = (paddr == `HSMFD_OFS_LINE);
	assign hitAny   = hitVsc | hitHctl | hitScmp | hitLine;

	always_comb begin
		vscRead = `HSMFD_ZERO32;
		vscRead[`HSMFD_VSC_EN_BIT]    = sepEnable_q;
		vscRead[`HSMFD_VSC_SELA_BIT]  = selTimerA_q;
		vscRead[`HSMFD_VSC_SELB_BIT]  = selTimerB_q;
		vscRead[`HSMFD_VSC_FLAG_BIT]  = fieldFlag_q;
		vscRead[`HSMFD_VSC_VALID_BIT] = fieldValid;
		vscRead[`HSMFD_VSC_VS_BIT]    = vertical_sync_out;
		vscRead[`HSMFD_VSC_MASK_BIT]  = hMask_q;
	end

	always_comb begin
		readMux = `HSMFD_ZERO32;
		if (hitVsc) begin
			readMux = vscRead;
		end else if (hitHctl) begin
			readMux[`HSMFD_LO_BYTE] = maskWidthCmp_q;
			readMux[`HSMFD_HI_BYTE] = compCmp_q;
		end else if (hitScmp) begin
			readMux[`HSMFD_LO_BYTE] = hMatchCmp_q;
			readMux[`HSMFD_HI_BYTE] = vMatchCmp_q;
		end else if (hitLine) begin
			readMux[`HSMFD_LO_BYTE] = lineCnt_q;
		end
	end

	// Answer is registered at setup: one access cycle, no extra wait
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q  <= `HSMFD_ZERO32;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= apbSetup;
			pslverr_q <= apbSetup & ~hitAny;
			if (apbSetup) begin
				prdata_q <= (pwrite | ~hitAny) ? `HSMFD_ZERO32 : readMux;
			end
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Compare values are taken as written; the range limits stay with software
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sepEnable_q    <= 1'b0;
			selTimerA_q    <= 1'b0;
			selTimerB_q    <= 1'b0;
			maskWidthCmp_q <= `HSMFD_RST_MASKW;
			compCmp_q      <= `HSMFD_RST_COMP;
			hMatchCmp_q    <= `HSMFD_RST_HCMP;
			vMatchCmp_q    <= `HSMFD_RST_VCMP;
		end else if (apbWrite) begin
			if (hitVsc) begin
				sepEnable_q <= pwdata[`HSMFD_VSC_EN_BIT];
				selTimerA_q <= pwdata[`HSMFD_VSC_SELA_BIT];
				selTimerB_q <= pwdata[`HSMFD_VSC_SELB_BIT];
			end
			if (hitHctl) begin
				maskWidthCmp_q <= pwdata[`HSMFD_LO_BYTE];
				compCmp_q      <= pwdata[`HSMFD_HI_BYTE];
			end
			if (hitScmp) begin
				hMatchCmp_q <= pwdata[`HSMFD_LO_BYTE];
				vMatchCmp_q <= pwdata[`HSMFD_HI_BYTE];
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign rawHsyncOut         = rawHs_q;
	assign compensatedHsyncOut = compHs_q;
	assign verticalSyncOut     = vertical_sync_out;
	assign fieldFlagOut        = fieldFlag_q;
	assign lineDropTimerATick  = timerATick_q;
	assign lineDropTimerBTick  = timerBTick_q;

endmodule : hsmfd_top

/* verification/hsmfd_sync_src.sv */
`timescale 1ns/1ps
// ****
// Composite sync source: high for hiT ticks, then low for loT ticks
// ****
module hsmfd_sync_src #(
	parameter int SYNC_DIV = 2
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Request
	input  wire logic       go,
	input  wire logic [8:0] hiT,
	input  wire logic [8:0] loT,
	// Line
	output logic            syncLine,
	output logic            busy
);
	int left_q;
	int hiLeft_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			left_q   <= 0;
			hiLeft_q <= 0;
		end else if (go && !busy) begin
			left_q   <= (hiT + loT) * SYNC_DIV;
			hiLeft_q <= hiT * SYNC_DIV;
		end else if (left_q > 0) begin
			left_q   <= left_q - 1;
			hiLeft_q <= (hiLeft_q > 0) ? hiLeft_q - 1 : 0;
		end
	end
	// Line idles low between requests, as a real sync source does
	assign syncLine = (hiLeft_q > 0);
	assign busy     = (left_q > 0);
endmodule : hsmfd_sync_src

/* verification/hsmfd_top_chk.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module hsmfd_top_chk #(
	parameter int SYNC_DIV = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Sync outputs and timer ticks
	input wire logic rawHsyncOut,
	input wire logic compensatedHsyncOut,
	input wire logic verticalSyncOut,
	input wire logic fieldFlagOut,
	input wire logic lineDropTimerATick,
	input wire logic lineDropTimerBTick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	int rawLen_q;
	int compLen_q;
	// High-time counters; a disable in mid-pulse would trip the width checks
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rawLen_q  <= 0;
			compLen_q <= 0;
		end else begin
			rawLen_q  <= rawHsyncOut ? rawLen_q + 1 : 0;
			compLen_q <= compensatedHsyncOut ? compLen_q + 1 : 0;
		end
	end
	AST_RESET_QUIET: assert property (
		$rose(rst_b) |-> !(rawHsyncOut || compensatedHsyncOut || fieldFlagOut))
		else $error("sync outputs not low after reset");
	AST_RAW_WIDTH: assert property (
		$fell(rawHsyncOut) |-> rawLen_q == 10 * SYNC_DIV)
		else $error("raw sync width wrong");
	AST_COMP_WIDTH: assert property (
		$fell(compensatedHsyncOut) |-> compLen_q == 10 * SYNC_DIV)
		else $error("compensated sync width wrong");
	AST_RAW_IN_COMP: assert property (
		$rose(rawHsyncOut) |-> ##[0:1] compensatedHsyncOut)
		else $error("raw sync missing from compensated sync");
	AST_TIMER_A_ONE: assert property (
		lineDropTimerATick |=> !lineDropTimerATick)
		else $error("timer tick longer than one cycle");
	AST_TIMER_B_CAUSE: assert property (
		lineDropTimerBTick |-> ##[0:1] rawHsyncOut)
		else $error("timer tick without raw sync");
	AST_FLAG_ON_VS: assert property (
		$changed(fieldFlagOut) |-> verticalSyncOut)
		else $error("field flag moved outside vertical sync");
	AST_PREADY_NEXT: assert property (
		psel && !penable |=> pready)
		else $error("no answer after setup");
	AST_PREADY_ONE: assert property (
		pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_WITH_READY: assert property (
		pslverr |-> pready)
		else $error("pslverr without pready");
endmodule : hsmfd_top_chk

/* verification/test_hsync_mask_field_discriminator.sv */
`timescale 1ns/1ps
`include "hsmfd_params.svh"

module test_hsync_mask_field_discriminator;
	localparam int DIV = 2;
	localparam logic [11:0] A_VSC = `HSMFD_OFS_VSC;
	localparam logic [11:0] A_HCTL = `HSMFD_OFS_HCTL;
	localparam logic [11:0] A_SCMP = `HSMFD_OFS_SCMP;
	localparam logic [11:0] A_LINE = `HSMFD_OFS_LINE;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        ref_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic        go      = 1'b0;
	logic [8:0]  hiT     = 9'h000;
	logic [8:0]  loT     = 9'h000;
	logic [31:0] seed    = 32'h0000_0027;
	logic [31:0] prdata, rdData;
	logic        pready, pslverr, rdErr, syncLine, busy;
	logic        rawHs, compHs, vertical_sync_out, flagOut, tickA, tickB;
	int          fails, checked, nRaw, nComp, nA, nB;

	hsmfd_top #(.SYNC_DIV(DIV)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compositeSyncIn(syncLine),
		.rawHsyncOut(rawHs), .compensatedHsyncOut(compHs), .verticalSyncOut(vertical_sync_out),
		.fieldFlagOut(flagOut), .lineDropTimerATick(tickA), .lineDropTimerBTick(tickB));
	hsmfd_sync_src #(.SYNC_DIV(DIV)) src (
		.ref_clk(ref_clk), .rst_b(rst_b), .go(go), .hiT(hiT), .loT(loT),
		.syncLine(syncLine), .busy(busy));

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge rawHs) nRaw++;
	always @(posedge compHs) nComp++;
	always @(posedge tickA) nA++;
	always @(posedge tickB) nB++;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [31:0] expHalf(input logic [31:0] w);
		return {16'h0000, w[15:0]};
	endfunction : expHalf
	function automatic logic [31:0] expFlags(input logic flag, input logic valid);
		return {22'h00_0000, valid, flag, 8'h00};
	endfunction : expFlags

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic bail(input string nm);
		fails++;
		$display("[FAIL] %s expected answer seen none", nm);
		print_verdict();
	endtask : bail
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) bail("pready");
		rdData  = prdata;
		rdErr   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] ex,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, ex & m, rdData & m);
	endtask : rdChk
	task automatic waitT(input int n);
		repeat (n * DIV) @(posedge ref_clk);
	endtask : waitT
	// Waits out the current line first, so requests never overlap
	task automatic send(input int hi, input int lo);
		int n;
		n = 0;
		@(posedge ref_clk);
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 2000) bail("sync source");
		hiT <= hi[8:0];
		loT <= lo[8:0];
		go  <= 1'b1;
		@(posedge ref_clk);
		go  <= 1'b0;
	endtask : send
	task automatic endTest(input string nm);
		$display("test %s done, mismatches so far %0d", nm, fails);
	endtask : endTest

	initial begin
		int r0;
		int c0;
		int a0;
		int b0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		// ****
		// Registers
		// ****
		rdChk("vsc", A_VSC, 32'h0000_0000, ALL);
		rdChk("hctl", A_HCTL, {16'h0000, `HSMFD_RST_COMP, `HSMFD_RST_MASKW}, ALL);
		rdChk("scmp", A_SCMP, {16'h0000, `HSMFD_RST_VCMP, `HSMFD_RST_HCMP}, ALL);
		apb(1'b1, 12'h010, ALL);
		chk("unmapped err", 32'h0000_0001, {31'h0, rdErr});
		apb(1'b1, A_VSC, 32'h0000_0F00);
		apb(1'b1, A_LINE, 32'h0000_00FF);
		rdChk("vsc ro", A_VSC, 32'h0000_0000, ALL);
		rdChk("line ro", A_LINE, 32'h0000_0000, ALL);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			apb(1'b1, i[0] ? A_SCMP : A_HCTL, seed);
			rdChk("cmp rand", i[0] ? A_SCMP : A_HCTL, expHalf(seed), ALL);
		end
		endTest("registers");
		// ****
		// Lines, mask window, timer source
		// ****
		apb(1'b1, A_HCTL, 32'h0000_C040);
		apb(1'b1, A_SCMP, 32'h0000_2004);
		apb(1'b1, A_VSC, 32'h0000_0003);
		r0 = nRaw;
		a0 = nA;
		b0 = nB;
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			send(8, 72 + int'(seed[2:0]));
			waitT(16);
			rdChk("mask set", A_VSC, 32'h0000_0800, 32'h0000_0800);
			waitT(55);
			rdChk("mask clear", A_VSC, 32'h0000_0000, 32'h0000_0800);
		end
		chk("raw count", 4, nRaw - r0);
		chk("comp count", 4, nComp);
		chk("timer a", 4, nA - a0);
		chk("timer b off", 0, nB - b0);
		endTest("lines");
		// Noise pulse inside the mask window
		send(8, 20);
		send(6, 46);
		waitT(30);
		apb(1'b0, A_LINE, 32'h0000_0000);
		chk("line kept", 1, rdData[7:0] > 8'h28);
		chk("noise ignored", 5, nRaw - r0);
		endTest("noise");
		// ****
		// Dropout and self-generated sync
		// ****
		apb(1'b1, A_VSC, 32'h0000_0007);
		c0 = nComp;
		send(0, 450);
		waitT(450);
		chk("comp rises", 2, nComp - c0);
		chk("raw idle", 5, nRaw - r0);
		chk("timer a idle", 5, nA - a0);
		send(8, 72);
		waitT(20);
		chk("timer b", 1, nB - b0);
		endTest("dropout");
		// ****
		// Field discrimination
		// ****
		// Vertical pulse starts inside the mask window, so its match is ignored
		send(8, 50);
		send(50, 60);
		waitT(110);
		rdChk("even", A_VSC, expFlags(1'b0, 1'b0), 32'h0000_0700);
		chk("even pin", 0, flagOut);
		send(50, 60);
		waitT(40);
		chk("vs pin", 1, vertical_sync_out);
		waitT(70);
		rdChk("odd", A_VSC, expFlags(1'b1, 1'b1), 32'h0000_0700);
		chk("odd pin", 1, flagOut);
		chk("vs pin low", 0, vertical_sync_out);
		apb(1'b1, A_VSC, 32'h0000_0000);
		rdChk("line off", A_LINE, 32'h0000_0000, ALL);
		rdChk("flag kept", A_VSC, 32'h0000_0100, 32'h0000_0100);
		endTest("field");
		print_verdict();
	end
endmodule : test_hsync_mask_field_discriminator

bind hsmfd_top hsmfd_top_chk #(.SYNC_DIV(SYNC_DIV)) chk_i (
	.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .rawHsyncOut(rawHsyncOut), .compensatedHsyncOut(compensatedHsyncOut),
	.verticalSyncOut(verticalSyncOut), .fieldFlagOut(fieldFlagOut),
	.lineDropTimerATick(lineDropTimerATick), .lineDropTimerBTick(lineDropTimerBTick));
